//--- hw/pipe_params.svh
// constants for the egress pipeline forward control block
// assumes: included by the design modules and by the test bench
`ifndef PIPE_PARAMS_SVH
`define PIPE_PARAMS_SVH
`define OFS_CTRL 12'h000
`define OFS_FRAMES 12'h004
`define OFS_DROPS 12'h008
`define OFS_LOOPS 12'h00C
`define CTRL_LOOP_ONCE_BIT 0
`define PT_DEFAULT 5'h00
`define PT_REWRITER_INNER 5'h03
`define PT_REWRITER_OUTER 5'h04
`define PT_REWRITER_PORT 5'h08
`define PT_LAST 5'h09
`define PT_ANALYZER_INNER 5'h10
`define PT_ANALYZER_OUTER 5'h11
`define PT_ANALYZER_PORT 5'h12
`define DP_FORCED 2'h0
`define TTL_FORCED 8'h01
`endif

//--- hw/pipe_pkg.sv
// types shared by the egress pipeline forward control modules
// assumes: compiled before every design module
package pipe_pkg;
  typedef enum logic [3:0] {
    act_none = 4'h0,
    inject_action = 4'h1,
    inject_masquerade_action = 4'h2,
    inject_central_action = 4'h3,
    extract_action = 4'h4,
    extract_up_endpoint_action = 4'h5,
    extract_late_action = 4'h6,
    rewriter_loopback_action = 4'h7,
    queue_loopback_action = 4'h8
  } pipe_action_t;
  typedef enum logic [1:0] {
    fwd_none = 2'h0,
    fwd_copy = 2'h1,
    redirect_select = 2'h2,
    fwd_discard = 2'h3
  } forward_select_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_walk = 2'b01,
    st_emit = 2'b10
  } fsm_t;
  typedef struct packed {
    logic [3:0] src_port;
    logic [3:0] dst_port;
    logic [4:0] pipe_point;
    pipe_action_t pipe_action;
    logic [7:0] cpu_mask;
    logic header_looped_flag;
    logic header_checksum_update_flag;
    logic [11:0] header_service_index;
    logic [1:0] header_drop_precedence;
    logic [7:0] header_label_hop_limit;
  } frame_hdr_t;
  typedef struct packed {
    logic valid;
    logic [4:0] point;
    forward_select_t forward_select;
    logic to_cpu;
    logic up_endpoint;
    logic [7:0] cpu_mask;
    logic set_fcs;
    logic set_isdx;
    logic [11:0] isdx;
    logic dp_zero;
    logic ttl_one;
  } stage_dec_t;
  typedef struct packed {
    logic copy;
    logic redirect;
    logic disc;
    logic [4:0] lbk_point;
    pipe_action_t lbk_action;
  } fwd_flags_t;
  function automatic logic is_inject(pipe_action_t a);
    return a inside {inject_action, inject_masquerade_action, inject_central_action,
                     queue_loopback_action};
  endfunction
  function automatic logic is_extract(pipe_action_t a);
    return a inside {extract_action, extract_up_endpoint_action, extract_late_action,
                     rewriter_loopback_action};
  endfunction
endpackage

//--- hw/entry_clear.sv
// entry handling of a frame header arriving from the analyzer
// assumes: purely combinational, fed from the input header port before it is registered
`include "pipe_params.svh"
module entry_clear import pipe_pkg::*; (
  input wire frame_hdr_t hdr_in,
  input wire logic cpu_injected,
  output frame_hdr_t hdr_out
);
  always_comb begin
    hdr_out = hdr_in;
    if (hdr_in.pipe_action == queue_loopback_action) begin
      // the action stays: it reads as an injection further on
      if (hdr_in.pipe_point == `PT_ANALYZER_PORT) begin
        hdr_out.pipe_point = `PT_REWRITER_PORT;
      end else if (hdr_in.pipe_point == `PT_ANALYZER_OUTER) begin
        hdr_out.pipe_point = `PT_REWRITER_OUTER;
      end else if (hdr_in.pipe_point == `PT_ANALYZER_INNER) begin
        hdr_out.pipe_point = `PT_REWRITER_INNER;
      end
    end else if (!cpu_injected && is_inject(hdr_in.pipe_action)) begin
      hdr_out.pipe_action = act_none;
      hdr_out.pipe_point = `PT_DEFAULT;
    end
  end
endmodule

//--- hw/stage_apply.sv
// one forwarding stage applied at the current pipeline point
// assumes: chained in priority order, combinational
`include "pipe_params.svh"
module stage_apply import pipe_pkg::*; (
  input wire frame_hdr_t hdr_in,
  input wire fwd_flags_t flg_in,
  input wire stage_dec_t dec,
  input wire logic [4:0] at_point,
  input wire logic is_oam,
  input wire logic loop_block,
  output frame_hdr_t hdr_out,
  output fwd_flags_t flg_out,
  output logic counted
);
  logic hit;
  logic injected;
  logic extracted;
  logic exists;
  logic may;
  pipe_action_t xact;
  always_comb begin
    hit = dec.valid && (dec.point == at_point);
    injected = is_inject(hdr_in.pipe_action);
    extracted = is_extract(hdr_in.pipe_action);
    exists = (hdr_in.pipe_action == act_none)
      || (injected && at_point >= hdr_in.pipe_point)
      || (extracted && at_point <= hdr_in.pipe_point);
    // an extraction at this very point already fixed forwarding here
    may = hit && exists && !(extracted && at_point == hdr_in.pipe_point)
      && !flg_in.redirect && !flg_in.disc;
    counted = hit && exists;
    xact = dec.up_endpoint ? extract_up_endpoint_action : extract_action;
    hdr_out = hdr_in;
    flg_out = flg_in;
    if (may) begin
      hdr_out.cpu_mask = hdr_in.cpu_mask | dec.cpu_mask;
      unique case (dec.forward_select)
        fwd_none: begin
        end
        fwd_copy: begin
          flg_out.copy = 1'b1;
          flg_out.lbk_point = at_point;
          flg_out.lbk_action = hdr_in.pipe_action;
        end
        redirect_select: begin
          if (dec.to_cpu || !loop_block) begin
            flg_out.redirect = 1'b1;
            hdr_out.pipe_point = at_point;
            hdr_out.pipe_action = dec.to_cpu ? xact : rewriter_loopback_action;
            hdr_out.header_looped_flag = hdr_in.header_looped_flag | !dec.to_cpu;
            flg_out.lbk_point = at_point;
            flg_out.lbk_action = hdr_out.pipe_action;
          end
        end
        fwd_discard: begin
          flg_out.disc = 1'b1;
          hdr_out.pipe_point = at_point;
          hdr_out.pipe_action = xact;
        end
      endcase
      if (is_oam) begin
        hdr_out.header_checksum_update_flag = hdr_in.header_checksum_update_flag
          | dec.set_fcs;
        if (dec.set_isdx) begin
          hdr_out.header_service_index = dec.isdx;
        end
        if (dec.dp_zero) begin
          hdr_out.header_drop_precedence = `DP_FORCED;
        end
        if (dec.ttl_one) begin
          hdr_out.header_label_hop_limit = `TTL_FORCED;
        end
      end
    end
  end
endmodule

//--- hw/egress_pipeline_forward_control.sv
// egress forward control: walks pipeline points per frame, applies
// copy, redirect, loopback and discard, and an apb register slave
// assumes: decisions of the three stages arrive with the frame header;
// tx_valid, lbk_valid and drop_pulse are one-cycle pulses, the far side takes them without stall
`include "pipe_params.svh"
module egress_pipeline_forward_control import pipe_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  input wire logic in_cpu_injected,
  input wire frame_hdr_t in_hdr,
  input wire stage_dec_t [2:0] in_dec,
  output logic in_ready,
  output logic tx_valid,
  output frame_hdr_t tx_hdr,
  output logic lbk_valid,
  output frame_hdr_t lbk_hdr,
  output logic drop_pulse,
  output logic [2:0] count_mask
);
  typedef struct packed {
    fsm_t st;
    logic [4:0] pt;
    frame_hdr_t hdr;
    fwd_flags_t flg;
    stage_dec_t [2:0] dec;
    logic [2:0] cnt;
    logic in_ready;
    logic tx_valid;
    frame_hdr_t tx_hdr;
    logic lbk_valid;
    frame_hdr_t lbk_hdr;
    logic drop;
    logic [2:0] count_mask;
    logic loop_once;
    logic [15:0] frames;
    logic [15:0] drops;
    logic [15:0] loops;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  state_t s_reg;
  state_t s_next;
  frame_hdr_t entry_hdr;
  frame_hdr_t hdr_ch [0:3];
  fwd_flags_t flg_ch [0:3];
  logic [2:0] cnt_ch;
  logic take;
  logic wr_hit;

  entry_clear u_entry (
    .hdr_in(in_hdr),
    .cpu_injected(in_cpu_injected),
    .hdr_out(entry_hdr)
  );

  // index 0 is the egress lookup, 1 the intermediate point, 2 the oam processor;
  // only these three and the entry clear may move point and action inside the block
  assign hdr_ch[0] = s_reg.hdr;
  assign flg_ch[0] = s_reg.flg;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_stage
      stage_apply u_stage (
        .hdr_in(hdr_ch[gi]),
        .flg_in(flg_ch[gi]),
        .dec(s_reg.dec[gi]),
        .at_point(s_reg.pt),
        .is_oam(gi == 2),
        .loop_block((gi == 0) && s_reg.loop_once && hdr_ch[gi].header_looped_flag),
        .hdr_out(hdr_ch[gi+1]),
        .flg_out(flg_ch[gi+1]),
        .counted(cnt_ch[gi])
      );
    end
  endgenerate

  assign take = in_valid && s_reg.in_ready && (s_reg.st == st_idle);
  assign wr_hit = psel && penable && pwrite && s_reg.pready;

  always_comb begin
    s_next = s_reg;
    s_next.tx_valid = 1'b0;
    s_next.lbk_valid = 1'b0;
    s_next.drop = 1'b0;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    unique case (s_reg.st)
      st_idle: begin
        if (take) begin
          s_next.hdr = entry_hdr;
          s_next.flg = '0;
          s_next.dec = in_dec;
          s_next.cnt = 3'h0;
          s_next.pt = `PT_DEFAULT;
          s_next.in_ready = 1'b0;
          s_next.st = st_walk;
          s_next.frames = s_reg.frames + 16'h0001;
        end
      end
      st_walk: begin
        s_next.hdr = hdr_ch[3];
        s_next.flg = flg_ch[3];
        s_next.cnt = s_reg.cnt | cnt_ch;
        s_next.pt = s_reg.pt + 5'h01;
        if (s_reg.pt == `PT_LAST) begin
          s_next.st = st_emit;
        end
      end
      st_emit: begin
        // original leaves only when neither redirected nor discarded
        s_next.tx_valid = !s_reg.flg.redirect && !s_reg.flg.disc;
        s_next.tx_hdr = s_reg.hdr;
        s_next.lbk_valid = s_reg.flg.copy || s_reg.flg.redirect;
        s_next.lbk_hdr = s_reg.hdr;
        s_next.lbk_hdr.src_port = s_reg.hdr.dst_port;
        s_next.lbk_hdr.pipe_point = s_reg.flg.lbk_point;
        s_next.lbk_hdr.pipe_action = s_reg.flg.lbk_action;
        s_next.drop = s_reg.flg.disc;
        s_next.count_mask = s_reg.cnt;
        if (s_reg.flg.disc) begin
          s_next.drops = s_reg.drops + 16'h0001;
        end
        if (s_reg.flg.copy || s_reg.flg.redirect) begin
          s_next.loops = s_reg.loops + 16'h0001;
        end
        s_next.in_ready = 1'b1;
        s_next.st = st_idle;
      end
      default: begin
        s_next.st = st_idle;
        s_next.in_ready = 1'b1;
      end
    endcase
    // apb: answer in the cycle after setup, write commits on the edge that ends it
    if (psel && !penable) begin
      s_next.pready = 1'b1;
      s_next.prdata = 32'h0000_0000;
      unique case (paddr)
        `OFS_CTRL: s_next.prdata[`CTRL_LOOP_ONCE_BIT] = s_reg.loop_once;
        `OFS_FRAMES: s_next.prdata[15:0] = s_reg.frames;
        `OFS_DROPS: s_next.prdata[15:0] = s_reg.drops;
        `OFS_LOOPS: s_next.prdata[15:0] = s_reg.loops;
        default: s_next.pslverr = 1'b1;
      endcase
    end
    // error stands only with pready, so it clears with the default above
    if (wr_hit && paddr == `OFS_CTRL) begin
      s_next.loop_once = pwdata[`CTRL_LOOP_ONCE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.in_ready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign in_ready = s_reg.in_ready;
  assign tx_valid = s_reg.tx_valid;
  assign tx_hdr = s_reg.tx_hdr;
  assign lbk_valid = s_reg.lbk_valid;
  assign lbk_hdr = s_reg.lbk_hdr;
  assign drop_pulse = s_reg.drop;
  assign count_mask = s_reg.count_mask;

  // checks kept beside the logic they guard
  property p_entry_clear;
    @(posedge clk) disable iff (!rst_b)
      (take && !in_cpu_injected && in_hdr.pipe_action inside
        {inject_action, inject_masquerade_action, inject_central_action})
      |=> (s_reg.hdr.pipe_action == act_none && s_reg.hdr.pipe_point == `PT_DEFAULT);
  endproperty
  a_entry_clear: assert property (p_entry_clear)
    else $error("analyzer injection action not cleared on entry");

  property p_qs_translate;
    @(posedge clk) disable iff (!rst_b)
      (take && in_hdr.pipe_action == queue_loopback_action
        && in_hdr.pipe_point == `PT_ANALYZER_PORT)
      |=> (s_reg.hdr.pipe_point == `PT_REWRITER_PORT);
  endproperty
  a_qs_translate: assert property (p_qs_translate)
    else $error("queue loopback point not translated");

  sequence s_emit_disc;
    s_reg.st == st_emit && s_reg.flg.disc;
  endsequence
  property p_discard_no_tx;
    @(posedge clk) disable iff (!rst_b)
      s_emit_disc |=> (drop_pulse && !tx_valid) ##1 !drop_pulse;
  endproperty
  a_discard_no_tx: assert property (p_discard_no_tx)
    else $error("discarded frame transmitted");

  property p_redirect_no_tx;
    @(posedge clk) disable iff (!rst_b)
      (s_reg.st == st_emit && s_reg.flg.redirect) |=> (lbk_valid && !tx_valid);
  endproperty
  a_redirect_no_tx: assert property (p_redirect_no_tx)
    else $error("redirected frame reached the port");

  property p_copy_both;
    @(posedge clk) disable iff (!rst_b)
      (s_reg.st == st_emit && s_reg.flg.copy && !s_reg.flg.redirect && !s_reg.flg.disc)
      |=> (tx_valid && lbk_valid && lbk_hdr.src_port == tx_hdr.dst_port);
  endproperty
  a_copy_both: assert property (p_copy_both)
    else $error("copy did not produce both frames");

  property p_final;
    @(posedge clk) disable iff (!rst_b)
      (s_reg.st == st_walk && (s_reg.flg.redirect || s_reg.flg.disc))
      |=> ($stable(s_reg.hdr.pipe_action) && $stable(s_reg.hdr.pipe_point));
  endproperty
  a_final: assert property (p_final)
    else $error("final decision changed later");

  property p_loop_once;
    @(posedge clk) disable iff (!rst_b)
      (s_reg.st == st_walk && s_reg.loop_once && s_reg.hdr.header_looped_flag
        && s_reg.dec[0].forward_select == redirect_select && !s_reg.dec[0].to_cpu)
      |-> !(flg_ch[1].redirect && !flg_ch[0].redirect);
  endproperty
  a_loop_once: assert property (p_loop_once)
    else $error("frame looped twice by the lookup");

  property p_looped_flag;
    @(posedge clk) disable iff (!rst_b)
      (lbk_valid && lbk_hdr.pipe_action == rewriter_loopback_action)
      |-> lbk_hdr.header_looped_flag;
  endproperty
  a_looped_flag: assert property (p_looped_flag)
    else $error("rewriter loopback without looped flag");

  property p_inject_hidden;
    @(posedge clk) disable iff (!rst_b)
      (s_reg.st == st_walk && is_inject(s_reg.hdr.pipe_action)
        && s_reg.pt < s_reg.hdr.pipe_point)
      |-> (cnt_ch == 3'h0 && flg_ch[3] == s_reg.flg);
  endproperty
  a_inject_hidden: assert property (p_inject_hidden)
    else $error("frame handled before its injection point");

  property p_extract_gone;
    @(posedge clk) disable iff (!rst_b)
      (s_reg.st == st_walk && is_extract(s_reg.hdr.pipe_action)
        && s_reg.pt > s_reg.hdr.pipe_point)
      |-> (cnt_ch == 3'h0 && hdr_ch[3] == s_reg.hdr);
  endproperty
  a_extract_gone: assert property (p_extract_gone)
    else $error("frame handled after its extraction point");

  property p_frame_len;
    @(posedge clk) disable iff (!rst_b)
      take |=> (s_reg.st == st_walk) ##10 (s_reg.st == st_emit) ##1 in_ready;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("point walk length wrong");

  property p_redirect_action;
    @(posedge clk) disable iff (!rst_b)
      (s_reg.st == st_walk && !s_reg.flg.redirect && flg_ch[3].redirect)
      |-> (hdr_ch[3].pipe_action inside {extract_action, extract_up_endpoint_action,
        rewriter_loopback_action} && hdr_ch[3].pipe_point == s_reg.pt);
  endproperty
  a_redirect_action: assert property (p_redirect_action)
    else $error("redirect assigned a wrong pipe action");

  property p_discard_action;
    @(posedge clk) disable iff (!rst_b)
      (s_reg.st == st_walk && !s_reg.flg.disc && flg_ch[3].disc)
      |-> (hdr_ch[3].pipe_action inside {extract_action, extract_up_endpoint_action}
        && hdr_ch[3].pipe_point == s_reg.pt);
  endproperty
  a_discard_action: assert property (p_discard_action)
    else $error("discard assigned a wrong pipe action");

  property p_keep_action;
    @(posedge clk) disable iff (!rst_b)
      (s_reg.st == st_walk && flg_ch[3].redirect == s_reg.flg.redirect
        && flg_ch[3].disc == s_reg.flg.disc)
      |-> (hdr_ch[3].pipe_action == s_reg.hdr.pipe_action
        && hdr_ch[3].pipe_point == s_reg.hdr.pipe_point);
  endproperty
  a_keep_action: assert property (p_keep_action)
    else $error("none or copy changed the pipe action");

  property p_mask_grow;
    @(posedge clk) disable iff (!rst_b)
      (s_reg.st == st_walk) |=> ((s_reg.hdr.cpu_mask & $past(s_reg.hdr.cpu_mask))
        == $past(s_reg.hdr.cpu_mask));
  endproperty
  a_mask_grow: assert property (p_mask_grow)
    else $error("cpu queue mask bit lost");

  property p_loop_source;
    @(posedge clk) disable iff (!rst_b)
      lbk_valid |-> (lbk_hdr.src_port == lbk_hdr.dst_port);
  endproperty
  a_loop_source: assert property (p_loop_source)
    else $error("looped frame source port not the destination port");

  property p_copy_reaches;
    @(posedge clk) disable iff (!rst_b)
      (s_reg.st == st_emit && s_reg.flg.copy) |=> lbk_valid;
  endproperty
  a_copy_reaches: assert property (p_copy_reaches)
    else $error("cpu copy lost");

  property p_queue_kept;
    @(posedge clk) disable iff (!rst_b)
      (take && in_hdr.pipe_action == queue_loopback_action)
      |=> (s_reg.hdr.pipe_action == queue_loopback_action);
  endproperty
  a_queue_kept: assert property (p_queue_kept)
    else $error("queue loopback action not kept");

  property p_cpu_keep;
    @(posedge clk) disable iff (!rst_b)
      (take && in_cpu_injected && in_hdr.pipe_action != queue_loopback_action)
      |=> (s_reg.hdr == $past(in_hdr));
  endproperty
  a_cpu_keep: assert property (p_cpu_keep)
    else $error("cpu injected header altered on entry");

  property p_busy_not_ready;
    @(posedge clk) disable iff (!rst_b)
      (s_reg.st != st_idle) |-> !in_ready;
  endproperty
  a_busy_not_ready: assert property (p_busy_not_ready)
    else $error("input ready high while busy");
endmodule

//--- verif/frame_partner.sv
// far side model: analyzer and queue system offering frames, plus the
// tx, loopback and discard sinks
// assumes: one emit pulse group per frame, sinks never stall
module frame_partner import pipe_pkg::*; (
  input wire logic clk,
  input wire logic in_ready,
  input wire logic tx_valid,
  input wire frame_hdr_t tx_hdr,
  input wire logic lbk_valid,
  input wire frame_hdr_t lbk_hdr,
  input wire logic drop_pulse,
  input wire logic [2:0] count_mask,
  output logic in_valid,
  output logic in_cpu_injected,
  output frame_hdr_t in_hdr,
  output stage_dec_t [2:0] in_dec
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef stage_dec_t [2:0] dec_arr_t;
  logic [2:0] got_pulse;
  logic [2:0] got_mask;
  frame_hdr_t got_tx_hdr;
  frame_hdr_t got_lbk_hdr;
  initial begin
    in_valid = 1'b0;
    in_cpu_injected = 1'b0;
    in_hdr = '0;
    in_dec = '0;
  end
  task automatic send(input logic cpu, input frame_hdr_t hdr, input dec_arr_t dec,
                      output logic ok);
    int n;
    ok = 1'b0;
    @(posedge clk);
    in_valid <= 1'b1;
    in_cpu_injected <= cpu;
    in_hdr <= hdr;
    in_dec <= dec;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (in_ready === 1'b1) break;
    end
    // released lines show the inverse so a stale sample cannot pass
    in_valid <= 1'b0;
    in_cpu_injected <= ~cpu;
    in_hdr <= frame_hdr_t'(~hdr);
    in_dec <= dec_arr_t'(~dec);
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      #1;
      if ((tx_valid | lbk_valid | drop_pulse) === 1'b1) begin
        got_pulse = {tx_valid, lbk_valid, drop_pulse};
        got_mask = count_mask;
        got_tx_hdr = tx_hdr;
        got_lbk_hdr = lbk_hdr;
        ok = 1'b1;
        break;
      end
    end
  endtask
endmodule

//--- verif/egress_pipeline_forward_control_test.sv
// self-checking bench for the egress forward control block
// assumes: frame side driven by frame_partner, registers over apb here
`include "pipe_params.svh"
module egress_pipeline_forward_control_test import pipe_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic in_valid, in_cpu_injected, in_ready, tx_valid, lbk_valid, drop_pulse, er, ok;
  frame_hdr_t in_hdr, tx_hdr, lbk_hdr, h;
  stage_dec_t [2:0] in_dec;
  stage_dec_t d, no;
  logic [2:0] count_mask;
  int bad_count, comparisons, frames, k;
  logic [4:0] from_pt [3];
  logic [4:0] to_pt [3];
  pipe_action_t clr_act [3];
  egress_pipeline_forward_control uut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
    .in_cpu_injected(in_cpu_injected), .in_hdr(in_hdr), .in_dec(in_dec),
    .in_ready(in_ready), .tx_valid(tx_valid), .tx_hdr(tx_hdr), .lbk_valid(lbk_valid),
    .lbk_hdr(lbk_hdr), .drop_pulse(drop_pulse), .count_mask(count_mask));
  frame_partner p (.clk(clk), .in_ready(in_ready), .tx_valid(tx_valid), .tx_hdr(tx_hdr),
    .lbk_valid(lbk_valid), .lbk_hdr(lbk_hdr), .drop_pulse(drop_pulse),
    .count_mask(count_mask), .in_valid(in_valid), .in_cpu_injected(in_cpu_injected),
    .in_hdr(in_hdr), .in_dec(in_dec));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      bad_count++;
      test_done();
    end
  endtask
  task automatic frame(input logic cpu, input stage_dec_t d2, input stage_dec_t d1,
                       input stage_dec_t d0);
    p.send(cpu, h, {d2, d1, d0}, ok);
    frames++;
    if (ok !== 1'b1) begin
      bad_count++;
      test_done();
    end
  endtask
  function automatic stage_dec_t mk(logic [4:0] pt, forward_select_t f, logic c, logic u,
                                    logic [7:0] m);
    return '{valid: 1'b1, point: pt, forward_select: f, to_cpu: c, up_endpoint: u,
             cpu_mask: m, default: '0};
  endfunction
  function automatic frame_hdr_t hd(logic [4:0] pt, pipe_action_t a, logic lf);
    return '{pipe_point: pt, pipe_action: a, dst_port: 4'h5, header_looped_flag: lf,
             default: '0};
  endfunction
  function automatic logic [31:0] pe(logic [4:0] pt, pipe_action_t a);
    return {23'h0, pt, a};
  endfunction
  function automatic logic [31:0] pa(frame_hdr_t x);
    return pe(x.pipe_point, x.pipe_action);
  endfunction
  function automatic logic [31:0] pl();
    return {29'h0, p.got_pulse};
  endfunction
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    no = '0;
    from_pt = '{`PT_ANALYZER_INNER, `PT_ANALYZER_OUTER, `PT_ANALYZER_PORT};
    to_pt = '{`PT_REWRITER_INNER, `PT_REWRITER_OUTER, `PT_REWRITER_PORT};
    clr_act = '{inject_action, inject_masquerade_action, inject_central_action};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, `OFS_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h1);
    apb(1'b0, `OFS_CTRL, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    $display("test registers done");
    for (k = 0; k < 3; k++) begin
      h = hd(5'h05, clr_act[k], 1'b0);
      frame(1'b0, no, no, no);
      check(pl(), 32'h4);
      check(pa(p.got_tx_hdr), pe(`PT_DEFAULT, act_none));
    end
    $display("test entry clear done");
    h = hd(5'h05, inject_action, 1'b0);
    frame(1'b1, mk(5'h06, fwd_none, 1'b0, 1'b0, 8'h00), mk(5'h05, fwd_copy, 1'b1, 1'b0,
          8'h00), mk(5'h04, redirect_select, 1'b1, 1'b0, 8'h00));
    check(pl(), 32'h6);
    check(32'(p.got_mask), 32'h6);
    check(pa(p.got_tx_hdr), pe(5'h05, inject_action));
    check(pa(p.got_lbk_hdr), pe(5'h05, inject_action));
    $display("test injected frame done");
    h = hd(5'h00, act_none, 1'b0);
    frame(1'b0, mk(5'h02, fwd_none, 1'b0, 1'b0, 8'h00), mk(5'h03, fwd_copy, 1'b1, 1'b0,
          8'h00), mk(5'h02, fwd_discard, 1'b1, 1'b0, 8'h00));
    check(pl(), 32'h1);
    check(32'(p.got_mask), 32'h5);
    $display("test discard done");
    frame(1'b0, no, mk(5'h06, fwd_none, 1'b0, 1'b0, 8'h10), mk(5'h03, fwd_copy, 1'b1,
          1'b0, 8'h01));
    check(pl(), 32'h6);
    check(32'(p.got_lbk_hdr.src_port), 32'h5);
    check(pa(p.got_lbk_hdr), pe(5'h03, act_none));
    check(32'(p.got_tx_hdr.cpu_mask), 32'h11);
    $display("test copy done");
    frame(1'b0, mk(5'h08, redirect_select, 1'b1, 1'b1, 8'h00), mk(5'h09, fwd_discard,
          1'b1, 1'b0, 8'h00), mk(5'h01, fwd_copy, 1'b1, 1'b0, 8'h02));
    check(pl(), 32'h2);
    check(pa(p.got_lbk_hdr), pe(5'h08, extract_up_endpoint_action));
    check(32'({p.got_lbk_hdr.dst_port, p.got_lbk_hdr.src_port}), 32'h55);
    check(32'(p.got_mask), 32'h5);
    $display("test copy upgraded done");
    for (k = 0; k < 2; k++) begin
      apb(1'b1, `OFS_CTRL, 32'(k));
      h = hd(5'h00, act_none, k[0]);
      frame(1'b0, no, no, mk(5'h07, redirect_select, 1'b0, 1'b0, 8'h00));
      check(pl(), (k == 1) ? 32'h4 : 32'h2);
      if (k == 0) begin
        check(pa(p.got_lbk_hdr), pe(5'h07, rewriter_loopback_action));
        check(32'(p.got_lbk_hdr.header_looped_flag), 32'h1);
      end
    end
    $display("test loopback done");
    for (k = 0; k < 3; k++) begin
      h = hd(from_pt[k], queue_loopback_action, 1'b0);
      h.header_drop_precedence = 2'h3;
      h.header_label_hop_limit = 8'h40;
      d = mk(to_pt[k], fwd_none, 1'b0, 1'b0, 8'h00);
      d.set_fcs = 1'b1;
      d.set_isdx = 1'b1;
      d.isdx = 12'hABC;
      d.dp_zero = 1'b1;
      d.ttl_one = 1'b1;
      frame(1'b0, d, no, mk(5'h02, redirect_select, 1'b1, 1'b0, 8'h00));
      check(pl(), 32'h4);
      check(pa(p.got_tx_hdr), pe(to_pt[k], queue_loopback_action));
      check(32'({p.got_tx_hdr.header_checksum_update_flag, p.got_tx_hdr.header_service_index,
            p.got_tx_hdr.header_drop_precedence, p.got_tx_hdr.header_label_hop_limit}),
            32'({1'b1, 12'hABC, `DP_FORCED, `TTL_FORCED}));
    end
    $display("test queue loopback done");
    h = hd(5'h05, extract_late_action, 1'b0);
    frame(1'b0, no, no, mk(5'h06, redirect_select, 1'b1, 1'b0, 8'h00));
    check(pl(), 32'h4);
    check(pa(p.got_tx_hdr), pe(5'h05, extract_late_action));
    $display("test late extract done");
    apb(1'b0, `OFS_FRAMES, 32'h0);
    check(rd, 32'(frames));
    apb(1'b0, `OFS_DROPS, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, `OFS_LOOPS, 32'h0);
    check(rd, 32'h4);
    $display("test counters done");
    test_done();
  end
endmodule
